/* File: rtl/acc_params.svh */
/*
 * Constants for the conversion controller: register offsets, field positions,
 * reset values and timing counts.
 * Assumes a 10 MHz core clock and a 32-bit AXI4-Lite register bus.
 */
// Notes on behaviour
// - every finished result is kept as an 8-bit unsigned value for software
// - control bits 2:0 pick which of eight analog inputs is converted
// - input at or above upper reference gives FFh, no overflow indication
// - input at or below lower reference gives 00h
// - a conversion lasts 64 clocks, the first 31.5 of them sampling; the code samples for 32 clocks
// - result is linear: 255 times input over reference span
// - after power-on, wait about 30 us, then convert continuously
// - end of conversion sets the done flag and stores result, no interrupt
// - any control write aborts, clears done flag and restarts conversion; the code leaves the flag set if a conversion finishes in the same cycle
// - done flag in bit 7 clears on result read or control write only; the code also clears it while the converter is not running
// - bit 5 switches the converter on (1) or off (0)
// - wait low-power state leaves the converter running as normal
// - halt disables converter; after wake-up the settling wait repeats
// - bit 4 always reads zero and ignores writes
// - analog pins stay readable as logic levels
// - result register is read-only, resets to 00h, spans 00h to FFh
// - channel code is binary: 000 is input 0 up to 111 input 7
`ifndef ACC_PARAMS_SVH
`define ACC_PARAMS_SVH

// register byte offsets
`define ACC_OFS_CTRL_STATUS 8'h00
`define ACC_OFS_RESULT 8'h04

// control/status field positions
`define ACC_BIT_DONE 7
`define ACC_BIT_POWER 5
`define ACC_CHAN_MSB 2
`define ACC_CHAN_LSB 0

// reset values
`define ACC_RST_CTRL_STATUS 8'h00
`define ACC_RST_RESULT 8'h00

// bus answers
`define ACC_RESP_OKAY 2'b00
`define ACC_RESP_SLVERR 2'b10

// timing
`define ACC_CLK_PERIOD_NS 100
`define ACC_STAB_TIME_NS 30000
`define ACC_STAB_CYCLES ((`ACC_STAB_TIME_NS + `ACC_CLK_PERIOD_NS - 1) / `ACC_CLK_PERIOD_NS)
`define ACC_SAMPLE_HALF_CYCLES 63
`define ACC_SAMPLE_CYCLES ((`ACC_SAMPLE_HALF_CYCLES + 1) / 2)
`define ACC_CONV_CYCLES 64
`define ACC_BIT_CYCLES ((`ACC_CONV_CYCLES - `ACC_SAMPLE_CYCLES) / 8)

`endif

/* File: rtl/acc_pkg.sv */
/*
 * Types shared by the conversion controller files.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package acc_pkg;
    typedef logic [7:0] acc_code_t;
    typedef logic [2:0] acc_chan_t;
    typedef enum logic [1:0] {ACC_OFF, ACC_SETTLE, ACC_RUN} acc_state_e;
endpackage

/* File: rtl/acc_sar_engine.sv */
/*
 * Successive approximation sequencer: sample phase, then eight trial bits.
 * Assumes an analog comparator on a pin, asynchronous to the core clock.
 */
`timescale 1ns/1ps
`include "acc_params.svh"

module acc_sar_engine (
    // clock and reset
    input wire logic i_clock,
    input wire logic i_rstn,
    // control
    input wire logic i_enable,
    input wire logic i_restart,
    // analog side
    input wire logic i_comp_above,
    output logic o_sample_hold,
    output acc_pkg::acc_code_t o_dac_code,
    // result
    output acc_pkg::acc_code_t o_result,
    output logic o_done
);
    import acc_pkg::*;

    logic [5:0] cnt_r;
    logic comp_meta_r;
    logic comp_r;
    logic [2:0] bit_idx;
    logic decide;
    acc_code_t mask;
    acc_code_t kept;
    acc_code_t dac_r;
    acc_code_t result_r;
    logic done_r;

    ////////////////////////////////////////////////////////////////////////
    // comparator synchroniser, two stages before any use
    always_ff @(posedge i_clock or negedge i_rstn) begin
        if (!i_rstn) begin
            comp_meta_r <= 1'b0;
            comp_r <= 1'b0;
        end else begin
            comp_meta_r <= i_comp_above;
            comp_r <= comp_meta_r;
        end
    end

    // cycle position in the 64-clock frame, restarted on abort
    always_ff @(posedge i_clock or negedge i_rstn) begin
        if (!i_rstn) begin
            cnt_r <= 6'h00;
        end else if (!i_enable || i_restart) begin
            cnt_r <= 6'h00;
        end else begin
            cnt_r <= cnt_r + 6'h01;
        end
    end

    // each bit gets four clocks, covering the two-stage comparator delay
    assign bit_idx = cnt_r[4:2];
    assign decide = i_enable && !i_restart && cnt_r[5] && (cnt_r[1:0] == 2'h3);
    assign mask = 8'h80 >> bit_idx;
    assign kept = comp_r ? dac_r : (dac_r & ~mask);

    ////////////////////////////////////////////////////////////////////////
    // trial code: MSB set at end of sampling, refined bit by bit
    always_ff @(posedge i_clock or negedge i_rstn) begin
        if (!i_rstn) begin
            dac_r <= 8'h00;
        end else if (!i_enable || i_restart) begin
            dac_r <= 8'h00;
        end else if (cnt_r == 6'(`ACC_SAMPLE_CYCLES - 1)) begin
            dac_r <= 8'h80;
        end else if (decide) begin
            dac_r <= (bit_idx == 3'h7) ? 8'h00 : (kept | (mask >> 1));
        end
    end

    // last decision latches the code and pulses done for one cycle
    always_ff @(posedge i_clock or negedge i_rstn) begin
        if (!i_rstn) begin
            result_r <= 8'h00;
            done_r <= 1'b0;
        end else begin
            done_r <= decide && (bit_idx == 3'h7);
            if (decide && (bit_idx == 3'h7)) begin
                result_r <= kept;
            end
        end
    end

    assign o_sample_hold = i_enable && (cnt_r < 6'(`ACC_SAMPLE_CYCLES));
    assign o_dac_code = dac_r;
    assign o_result = result_r;
    assign o_done = done_r;

    ////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (!i_rstn);

    sequence s_frame_start;
        i_enable && !i_restart && (cnt_r == 6'h00);
    endsequence

    sample_window_a: assert property ((s_frame_start ##1 (i_enable && !i_restart) [*7]) |-> o_sample_hold)
        else $error("sample phase shorter than expected");
    frame_period_a: assert property (
        (o_done && i_enable) ##1 (i_enable && !i_restart) [*8] |-> !o_done)
        else $error("done pulses too close together");
    // done follows the last decision of an unbroken 64-clock frame
    done_spacing_a: assert property ((i_enable && !i_restart && cnt_r == 6'h3F) |=> o_done)
        else $error("done not seen 64 clocks after frame start");
    full_scale_a: assert property (
        ((i_enable && !i_restart && cnt_r == 6'h20) ##1 (i_enable && !i_restart && comp_r) [*8]) |-> dac_r[7])
        else $error("trial code lost its top bit");
endmodule

/* File: rtl/acc_conv_ctrl.sv */
/*
 * Top of the conversion controller: AXI4-Lite register slave, power and
 * settling control, done flag and result register, analog mux select.
 * Assumes low-power requests come from logic on the same clock, and the
 * comparator and pin levels arrive asynchronously.
 */
// Design decisions made here: the AXI4-Lite slave port and the address map.
`timescale 1ns/1ps
`include "acc_params.svh"

module acc_conv_ctrl (
    // clock and reset
    input wire logic i_clock,
    input wire logic i_rstn,
    // axi4-lite write address
    input wire logic i_awvalid,
    output logic o_awready,
    input wire logic [7:0] i_awaddr,
    // axi4-lite write data
    input wire logic i_wvalid,
    output logic o_wready,
    input wire logic [31:0] i_wdata,
    input wire logic [3:0] i_wstrb,
    // axi4-lite write response
    output logic o_bvalid,
    input wire logic i_bready,
    output logic [1:0] o_bresp,
    // axi4-lite read address
    input wire logic i_arvalid,
    output logic o_arready,
    input wire logic [7:0] i_araddr,
    // axi4-lite read data
    output logic o_rvalid,
    input wire logic i_rready,
    output logic [31:0] o_rdata,
    output logic [1:0] o_rresp,
    // low-power state from the power controller
    input wire logic i_halt_mode,
    // analog side
    input wire logic i_comp_above,
    output logic o_converter_power,
    output acc_pkg::acc_chan_t o_input_channel_select,
    output logic o_sample_hold,
    output acc_pkg::acc_code_t o_dac_code,
    // digital view of the analog pins
    input wire logic [7:0] i_ain_pin,
    output logic [7:0] o_ain_level
);
    import acc_pkg::*;

    acc_state_e state_r;
    logic [8:0] settle_cnt_r;
    logic converter_power_on_r;
    acc_chan_t chan_r;
    logic conversion_done_flag_r;
    acc_code_t conversion_result_register_r;
    logic [7:0] pin_meta_r;
    logic [7:0] pin_level_r;

    logic aw_got_r;
    logic w_got_r;
    logic [7:0] awaddr_r;
    logic [31:0] wdata_r;
    logic [3:0] wstrb_r;
    logic bvalid_r;
    logic [1:0] bresp_r;
    logic rvalid_r;
    logic [31:0] rdata_r;
    logic [1:0] rresp_r;

    logic wr_fire;
    logic ctrl_wr;
    logic rd_fire;
    logic rd_result;
    logic power_req;
    logic eng_enable;
    logic eng_done;
    acc_code_t eng_result;
    logic [7:0] ctrl_view;

    ////////////////////////////////////////////////////////////////////////
    // write channel capture; address and data may come in either order
    assign o_awready = !aw_got_r && !bvalid_r;
    assign o_wready = !w_got_r && !bvalid_r;
    assign wr_fire = aw_got_r && w_got_r;
    assign ctrl_wr = wr_fire && (awaddr_r == `ACC_OFS_CTRL_STATUS) && wstrb_r[0];

    always_ff @(posedge i_clock or negedge i_rstn) begin
        if (!i_rstn) begin
            aw_got_r <= 1'b0;
            awaddr_r <= 8'h00;
        end else if (i_awvalid && o_awready) begin
            aw_got_r <= 1'b1;
            awaddr_r <= i_awaddr;
        end else if (wr_fire) begin
            aw_got_r <= 1'b0;
        end
    end

    always_ff @(posedge i_clock or negedge i_rstn) begin
        if (!i_rstn) begin
            w_got_r <= 1'b0;
            wdata_r <= 32'h0000_0000;
            wstrb_r <= 4'h0;
        end else if (i_wvalid && o_wready) begin
            w_got_r <= 1'b1;
            wdata_r <= i_wdata;
            wstrb_r <= i_wstrb;
        end else if (wr_fire) begin
            w_got_r <= 1'b0;
        end
    end

    // response; the result register is read-only, so writes to it fail
    always_ff @(posedge i_clock or negedge i_rstn) begin
        if (!i_rstn) begin
            bvalid_r <= 1'b0;
            bresp_r <= `ACC_RESP_OKAY;
        end else if (wr_fire) begin
            bvalid_r <= 1'b1;
            bresp_r <= (awaddr_r == `ACC_OFS_CTRL_STATUS) ? `ACC_RESP_OKAY : `ACC_RESP_SLVERR;
        end else if (i_bready) begin
            bvalid_r <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // read channel; data sampled at the address handshake
    assign o_arready = !rvalid_r;
    assign rd_fire = i_arvalid && o_arready;
    assign rd_result = rd_fire && (i_araddr == `ACC_OFS_RESULT);

    // bits 6, 4 and 3 are not stored and always read zero
    always_comb begin
        ctrl_view = 8'h00;
        ctrl_view[`ACC_BIT_DONE] = conversion_done_flag_r;
        ctrl_view[`ACC_BIT_POWER] = converter_power_on_r;
        ctrl_view[`ACC_CHAN_MSB:`ACC_CHAN_LSB] = chan_r;
    end

    always_ff @(posedge i_clock or negedge i_rstn) begin
        if (!i_rstn) begin
            rvalid_r <= 1'b0;
            rdata_r <= 32'h0000_0000;
            rresp_r <= `ACC_RESP_OKAY;
        end else if (rd_fire) begin
            rvalid_r <= 1'b1;
            if (i_araddr == `ACC_OFS_CTRL_STATUS) begin
                rdata_r <= {24'h00_0000, ctrl_view};
                rresp_r <= `ACC_RESP_OKAY;
            end else if (i_araddr == `ACC_OFS_RESULT) begin
                rdata_r <= {24'h00_0000, conversion_result_register_r};
                rresp_r <= `ACC_RESP_OKAY;
            end else begin
                rdata_r <= 32'h0000_0000;
                rresp_r <= `ACC_RESP_SLVERR;
            end
        end else if (i_rready) begin
            rvalid_r <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // software-written fields: power bit and channel code
    always_ff @(posedge i_clock or negedge i_rstn) begin
        if (!i_rstn) begin
            converter_power_on_r <= 1'((`ACC_RST_CTRL_STATUS >> `ACC_BIT_POWER) & 8'h01);
            chan_r <= 3'h0;
        end else if (ctrl_wr) begin
            converter_power_on_r <= wdata_r[`ACC_BIT_POWER];
            chan_r <= wdata_r[`ACC_CHAN_MSB:`ACC_CHAN_LSB];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // power sequencing; wait mode has no input here since it changes nothing
    assign power_req = converter_power_on_r && !i_halt_mode;

    always_ff @(posedge i_clock or negedge i_rstn) begin
        if (!i_rstn) begin
            state_r <= ACC_OFF;
            settle_cnt_r <= 9'h000;
        end else begin
            case (state_r)
                ACC_OFF: begin
                    settle_cnt_r <= 9'h000;
                    if (power_req) begin
                        state_r <= ACC_SETTLE;
                    end
                end
                ACC_SETTLE: begin
                    if (!power_req) begin
                        state_r <= ACC_OFF;
                    end else if (settle_cnt_r == 9'(`ACC_STAB_CYCLES - 1)) begin
                        state_r <= ACC_RUN;
                    end else begin
                        settle_cnt_r <= settle_cnt_r + 9'h001;
                    end
                end
                ACC_RUN: begin
                    if (!power_req) begin
                        state_r <= ACC_OFF;
                    end
                end
                default: begin
                    state_r <= ACC_OFF;
                end
            endcase
        end
    end

    assign eng_enable = (state_r == ACC_RUN);

    ////////////////////////////////////////////////////////////////////////
    // done flag: a finishing conversion beats a control-write or result-read clear in the same cycle
    always_ff @(posedge i_clock or negedge i_rstn) begin
        if (!i_rstn) begin
            conversion_done_flag_r <= 1'b0;
        end else if (!eng_enable) begin
            conversion_done_flag_r <= 1'b0;
        end else if (eng_done) begin
            conversion_done_flag_r <= 1'b1;
        end else if (ctrl_wr || rd_result) begin
            conversion_done_flag_r <= 1'b0;
        end
    end

    // result register follows every finished conversion
    always_ff @(posedge i_clock or negedge i_rstn) begin
        if (!i_rstn) begin
            conversion_result_register_r <= `ACC_RST_RESULT;
        end else if (eng_done) begin
            conversion_result_register_r <= eng_result;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // analog pins stay readable; two stages since they are asynchronous
    always_ff @(posedge i_clock or negedge i_rstn) begin
        if (!i_rstn) begin
            pin_meta_r <= 8'h00;
            pin_level_r <= 8'h00;
        end else begin
            pin_meta_r <= i_ain_pin;
            pin_level_r <= pin_meta_r;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // sequencer; a control write restarts it from the sample phase
    acc_sar_engine u_sar (
        .i_clock(i_clock),
        .i_rstn(i_rstn),
        .i_enable(eng_enable),
        .i_restart(ctrl_wr),
        .i_comp_above(i_comp_above),
        .o_sample_hold(o_sample_hold),
        .o_dac_code(o_dac_code),
        .o_result(eng_result),
        .o_done(eng_done)
    );

    assign o_converter_power = power_req;
    assign o_input_channel_select = chan_r;
    assign o_ain_level = pin_level_r;
    assign o_bvalid = bvalid_r;
    assign o_bresp = bresp_r;
    assign o_rvalid = rvalid_r;
    assign o_rdata = rdata_r;
    assign o_rresp = rresp_r;

    ////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (!i_rstn);

    sequence s_power_up;
        (state_r == ACC_OFF) ##1 (state_r == ACC_SETTLE);
    endsequence

    settle_hold_a: assert property (s_power_up ##1 power_req [*8] |-> (state_r == ACC_SETTLE))
        else $error("settling ended too early");
    settle_len_a: assert property (
        (state_r == ACC_SETTLE && settle_cnt_r == 9'(`ACC_STAB_CYCLES - 1) && power_req) |=> state_r == ACC_RUN)
        else $error("run not entered after settling");
    idle_flag_a: assert property ((state_r != ACC_RUN) |=> !conversion_done_flag_r)
        else $error("done flag set while not running");
    write_clear_a: assert property ((ctrl_wr && !eng_done && eng_enable) |=> !conversion_done_flag_r)
        else $error("control write left done flag set");
    read_clear_a: assert property ((rd_result && !eng_done) |=> !conversion_done_flag_r)
        else $error("result read left done flag set");
    done_store_a: assert property (
        (eng_done && eng_enable) |=> conversion_done_flag_r && conversion_result_register_r == $past(eng_result))
        else $error("finished conversion not recorded");
    reserved_zero_a: assert property (
        (rd_fire && i_araddr == `ACC_OFS_CTRL_STATUS) |=> o_rdata[31:8] == 24'h00_0000 && !o_rdata[4])
        else $error("reserved control bits read non-zero");
    halt_off_a: assert property (i_halt_mode |=> state_r == ACC_OFF)
        else $error("converter kept running in halt");
endmodule

/* File: dv/acc_analog_model.sv */
/* Analog side of the converter: eight input levels, a sample-and-hold and
   a comparator against the trial code. Assumes levels in 1/1023 of span. */
`timescale 1ns/1ps

module acc_analog_model
    import acc_pkg::*;
(
    // clock
    input wire logic i_clock,
    // converter side
    input wire logic i_power,
    input wire acc_chan_t i_chan,
    input wire logic i_sample,
    input wire acc_code_t i_dac,
    input wire logic [79:0] i_level,
    // comparator
    output logic o_comp_above
);
    logic [9:0] held;
    logic toggle;
    initial begin
        held = 10'h000;
        toggle = 1'h0;
    end
    ////////////////////////////////////////
    // track the chosen input while sampling, frozen afterwards
    always @(posedge i_clock) begin
        toggle <= ~toggle;
        if (i_power && i_sample) begin
            held <= i_level[i_chan*10 +: 10];
        end
    end
    // unpowered comparator gives no usable answer, so it wanders
    always_comb begin
        if (!i_power) begin
            o_comp_above = toggle;
        end else begin
            o_comp_above = (32'(held) * 32'hFF) >= (32'(i_dac) * 32'h3FF);
        end
    end
endmodule

/* File: dv/acc_conv_ctrl_bench.sv */
/* Self-checking bench for the conversion controller.
   Assumes the analog model and an AXI4-Lite master driven from here. */
`timescale 1ns/1ps
`include "acc_params.svh"
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin mismatches++; \
    $display("BAD t=%0t got=%h exp=%h", $time, g, e); end end

module acc_conv_ctrl_bench;
    import acc_pkg::*;
    logic i_clock = 1'h0;
    logic i_rstn = 1'h0;
    logic i_awvalid = 1'h0;
    logic i_wvalid = 1'h0;
    logic i_bready = 1'h0;
    logic i_arvalid = 1'h0;
    logic i_rready = 1'h0;
    logic i_halt_mode = 1'h0;
    logic [7:0] i_awaddr = 8'h00;
    logic [7:0] i_araddr = 8'h00;
    logic [7:0] i_ain_pin = 8'h00;
    logic [31:0] i_wdata = 32'h0;
    logic [3:0] i_wstrb = 4'h0;
    logic [79:0] lvl_bus = 80'h0;
    logic o_awready, o_wready, o_bvalid, o_arready, o_rvalid;
    logic o_converter_power, o_sample_hold, comp;
    logic [1:0] o_bresp, o_rresp, resp;
    logic [31:0] o_rdata, rd_data;
    acc_chan_t o_chan;
    acc_code_t o_dac;
    logic [7:0] o_ain_level;
    logic [9:0] lvl [8];
    logic prev_s = 1'h0;
    int run = 0, hi_len = 0, lo_len = 0;
    int mismatches = 0, cmp_count = 0;
    int ch;

    always #50 i_clock = ~i_clock;

    acc_conv_ctrl dut (.i_clock(i_clock), .i_rstn(i_rstn), .i_awvalid(i_awvalid), .o_awready(o_awready),
        .i_awaddr(i_awaddr), .i_wvalid(i_wvalid), .o_wready(o_wready), .i_wdata(i_wdata),
        .i_wstrb(i_wstrb), .o_bvalid(o_bvalid), .i_bready(i_bready), .o_bresp(o_bresp),
        .i_arvalid(i_arvalid), .o_arready(o_arready), .i_araddr(i_araddr), .o_rvalid(o_rvalid),
        .i_rready(i_rready), .o_rdata(o_rdata), .o_rresp(o_rresp), .i_halt_mode(i_halt_mode),
        .i_comp_above(comp), .o_converter_power(o_converter_power), .o_input_channel_select(o_chan),
        .o_sample_hold(o_sample_hold), .o_dac_code(o_dac), .i_ain_pin(i_ain_pin),
        .o_ain_level(o_ain_level));

    acc_analog_model u_analog (.i_clock(i_clock), .i_power(o_converter_power), .i_chan(o_chan),
        .i_sample(o_sample_hold), .i_dac(o_dac), .i_level(lvl_bus), .o_comp_above(comp));

    ////////////////////////////////////////
    // lengths of the last sampling and trial phases
    always @(posedge i_clock) begin
        prev_s <= o_sample_hold;
        if (o_sample_hold != prev_s) begin
            if (prev_s) hi_len <= run;
            else lo_len <= run;
            run <= 1;
        end else begin
            run <= run + 1;
        end
    end

    // expected code: floor of 255 times level over span
    function automatic acc_code_t exp_code(input logic [9:0] v);
        return 8'((32'(v) * 32'hFF) / 32'h3FF);
    endfunction

    ////////////////////////////////////////
    // write: address and data offered together, each dropped once taken
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic aw_ok;
        logic w_ok;
        logic aw_rdy;
        logic w_rdy;
        logic b_ok;
        aw_ok = 1'h0;
        w_ok = 1'h0;
        i_awvalid <= 1'h1;
        i_awaddr <= a;
        i_wvalid <= 1'h1;
        i_wdata <= d;
        i_wstrb <= 4'hF;
        // readies are looked at mid-cycle, where they stand for the coming edge
        while (!(aw_ok && w_ok)) begin
            @(negedge i_clock);
            aw_rdy = o_awready;
            w_rdy = o_wready;
            @(posedge i_clock);
            if (!aw_ok && aw_rdy) begin
                aw_ok = 1'h1;
                i_awvalid <= 1'h0;
            end
            if (!w_ok && w_rdy) begin
                w_ok = 1'h1;
                i_wvalid <= 1'h0;
            end
        end
        i_bready <= 1'h1;
        do begin
            @(negedge i_clock);
            b_ok = o_bvalid;
            resp = o_bresp;
            @(posedge i_clock);
        end while (!b_ok);
        i_bready <= 1'h0;
    endtask

    task automatic rd(input logic [7:0] a);
        logic ar_ok;
        logic r_ok;
        i_arvalid <= 1'h1;
        i_araddr <= a;
        do begin
            @(negedge i_clock);
            ar_ok = o_arready;
            @(posedge i_clock);
        end while (!ar_ok);
        i_arvalid <= 1'h0;
        i_rready <= 1'h1;
        do begin
            @(negedge i_clock);
            r_ok = o_rvalid;
            rd_data = o_rdata;
            resp = o_rresp;
            @(posedge i_clock);
        end while (!r_ok);
        i_rready <= 1'h0;
    endtask

    // poll the flag; reading control leaves it alone
    task automatic wait_done;
        int n;
        n = 0;
        do begin
            rd(`ACC_OFS_CTRL_STATUS);
            n++;
        end while (!rd_data[7] && n < 200);
        `CHK(rd_data[7], 1'h1)
    endtask

    task close_out;
        $display("mismatches=%0d comparisons=%0d", mismatches, cmp_count);
        if (mismatches == 0 && cmp_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // watchdog well beyond the expected few thousand cycles
    initial begin
        repeat (20000) @(posedge i_clock);
        mismatches++;
        close_out;
    end

    ////////////////////////////////////////
    initial begin
        void'($urandom(32'hF7C0));
        for (int i = 0; i < 8; i++) lvl[i] = 10'($urandom_range(32'h3FE, 32'h1));
        lvl[3] = 10'h3FF;
        lvl[5] = 10'h000;
        repeat (12) @(posedge i_clock);
        i_rstn <= 1'h1;
        for (int i = 0; i < 8; i++) lvl_bus[i*10 +: 10] <= lvl[i];
        rd(`ACC_OFS_CTRL_STATUS);
        `CHK(rd_data, 32'h0)
        rd(`ACC_OFS_RESULT);
        `CHK(rd_data, 32'h0)
        rd(8'h08);
        `CHK({resp, rd_data}, {`ACC_RESP_SLVERR, 32'h0})
        // every channel, first one through settling; bit 4 written as one
        for (int i = 0; i < 8; i++) begin
            ch = (i + 7) % 8;
            wr(`ACC_OFS_CTRL_STATUS, 32'h30 | ch);
            `CHK(o_chan, 3'(ch))
            `CHK(o_converter_power, 1'h1)
            rd(`ACC_OFS_CTRL_STATUS);
            `CHK(rd_data, 32'h20 | ch)
            if (i == 0) begin
                repeat (250) @(posedge i_clock);
                rd(`ACC_OFS_CTRL_STATUS);
                `CHK(rd_data[7], 1'h0)
            end
            wait_done;
            repeat (20) @(posedge i_clock);
            rd(`ACC_OFS_CTRL_STATUS);
            `CHK(rd_data[7], 1'h1)
            rd(`ACC_OFS_RESULT);
            `CHK(rd_data, {24'h0, exp_code(lvl[ch])})
            rd(`ACC_OFS_CTRL_STATUS);
            `CHK(rd_data[7], 1'h0)
            wait_done;
        end
        `CHK(hi_len, 32)
        `CHK(lo_len, 32)
        wr(`ACC_OFS_RESULT, 32'hA5);
        `CHK(resp, `ACC_RESP_SLVERR)
        rd(`ACC_OFS_RESULT);
        `CHK(rd_data, {24'h0, exp_code(lvl[6])})
        // deep low-power state, then wake-up settling again
        i_halt_mode <= 1'h1;
        repeat (4) @(posedge i_clock);
        `CHK(o_converter_power, 1'h0)
        rd(`ACC_OFS_CTRL_STATUS);
        `CHK(rd_data[7], 1'h0)
        i_halt_mode <= 1'h0;
        repeat (250) @(posedge i_clock);
        rd(`ACC_OFS_CTRL_STATUS);
        `CHK(rd_data[7], 1'h0)
        wait_done;
        // switched off: no conversion, no flag
        wr(`ACC_OFS_CTRL_STATUS, 32'h06);
        `CHK(o_converter_power, 1'h0)
        repeat (400) @(posedge i_clock);
        rd(`ACC_OFS_CTRL_STATUS);
        `CHK(rd_data, 32'h06)
        // pins stay plain inputs and readable as levels
        for (int i = 0; i < 4; i++) begin
            i_ain_pin <= 8'($urandom);
            repeat (3) @(posedge i_clock);
            `CHK(o_ain_level, i_ain_pin)
        end
        close_out;
    end
endmodule
